// ---- hw/dac_lockout_defines.svh ----
// Offsets, field positions, reset values and command codes of the DAC
// lockout control block. Included by the block itself.
`ifndef DAC_LOCKOUT_DEFINES_SVH
`define DAC_LOCKOUT_DEFINES_SVH

// APB register byte offsets
`define REG_LINK_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DAC_A 8'h08
`define REG_DAC_B 8'h0c
`define REG_LAST_CMD 8'h10

// Link control fields and reset value
`define LINK_ENABLE_BIT 0
`define LINK_CTRL_RESET 1'b1

// Serial frame length and field positions
`define FRAME_BITS 6'd32
`define CMD_HI 27
`define CMD_LO 24
`define ADDR_HI 23
`define ADDR_LO 20
`define DATA_HI 19
`define DATA_LO 4
`define PD_MODE_HI_BIT 9
`define PD_MODE_LO_BIT 8
`define SEL_A_BIT 0
`define SEL_B_BIT 3

// Command codes
`define CMD_WRITE_INPUT 4'h0
`define CMD_UPDATE_DAC 4'h1
`define CMD_WRITE_UPDATE_ALL 4'h2
`define CMD_WRITE_UPDATE 4'h3
`define CMD_POWER 4'h4
`define CMD_CLEAR_CODE 4'h5
`define CMD_OUTPUT_UPDATE_N_MASK 4'h6

// Channel addresses
`define ADDR_DAC_A 4'h0
`define ADDR_DAC_B 4'h1
`define ADDR_ALL 4'hf

// Clear code values and reset values
`define CLEAR_ZERO 16'h0000
`define CLEAR_MID 16'h8000
`define CLEAR_FULL 16'hffff
`define CLEAR_CODE_RESET 2'h0
`define CLEAR_CODE_NOP 2'h3
`define PD_NORMAL 2'h0
`define DAC_RESET 16'h0000

`endif

// ---- hw/dac_lockout_pkg.sv ----
// Types shared by the DAC lockout control block.
// Assumes the defines header sits beside it on the include path.
package dac_lockout_pkg;

  // Serial link receiver states
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_SHIFT,
    LINK_DONE,
    LINK_ABORTED
  } link_state_type;

  // Whole state of the block
  typedef struct packed {
    link_state_type link_state;
    logic sclk_q;
    logic lock_q;
    logic clr_q;
    logic upd_q;
    logic [31:0] shift;
    logic [5:0] bit_count;
    logic [1:0][15:0] input_reg;
    logic [1:0][15:0] dac_reg;
    logic [1:0][1:0] pd_mode;
    logic [1:0] clear_code;
    logic [1:0] output_update_n_mask;
    logic link_enable;
    logic [7:0] last_cmd;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dac_state_type;

endpackage : dac_lockout_pkg

// ---- hw/sync_two_ff.sv ----
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes each bit changes slowly compared with pclk.
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Both stages in one record
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type state; // Registered stages
  sync_state_type next_state; // Next stage values

  // First stage feeds only the second
  always_comb begin
    next_state.first = async_in;
    next_state.second = state.first;
  end

  // Register both stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= {RESET_VALUE, RESET_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;

endmodule : sync_two_ff

// ---- hw/power_down_lockout_control.sv ----
// Serial command receiver with power-down lockout for a dual-channel DAC.
// Assumes a 50 MHz pclk, an APB master, and a serial clock well below pclk.
// Contract
// - Lockout low blocks software power-down requests
// - Lockout falling aborts frame in progress
// - Lockout falling clears all power-down modes
// - Lockout rising keeps channels in normal
// - Lockout rising re-enables power-down at once
// - Clear loads clear code, exits power-down
// - Clear beats output update and lockout
// - Data bits sampled on serial rising
// - 32-bit frame acts at 32nd falling
// - Mode field 00 normal, else power-down
// - Select bits 3 and 0 pick channels
`timescale 1ns/1ns
`include "dac_lockout_defines.svh"
module power_down_lockout_control
  import dac_lockout_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock,
  input wire logic frame_select_n,
  input wire logic serial_data_in,
  input wire logic lockout_n,
  input wire logic async_clear_n,
  input wire logic output_update_n,
  output logic [15:0] dac_a_value,
  output logic [15:0] dac_b_value,
  output logic [1:0] pd_mode_a,
  output logic [1:0] pd_mode_b
);

  dac_state_type state; // All registered state
  dac_state_type next_state; // Next value of it
  logic [5:0] pins_sync; // Pins after two flip-flops
  logic sclk_s; // Synchronised serial clock
  logic fs_n_s; // Synchronised frame select
  logic din_s; // Synchronised data
  logic lock_n_s; // Synchronised lockout level
  logic clr_n_s; // Synchronised clear
  logic upd_n_s; // Synchronised output update
  logic sclk_rise; // Serial clock rising edge
  logic sclk_fall; // Serial clock falling edge
  logic lock_fall; // Lockout asserted
  logic clr_fall; // Clear asserted
  logic upd_fall; // Output update asserted
  logic execute; // Full frame accepted this cycle
  logic [31:0] word; // Frame being executed
  logic [3:0] cmd; // Command field
  logic [3:0] addr; // Channel address field
  logic [15:0] data; // Data field
  logic power_down_mode_hi; // Upper mode bit
  logic power_down_mode_lo; // Lower mode bit
  logic [1:0] sel; // Channels picked by the frame
  logic [15:0] clear_value; // Value loaded by clear
  logic apb_access; // APB access phase

  // All six asynchronous pins pass two flops first; APB inputs are used directly
  sync_two_ff #(
    .WIDTH(6),
    .RESET_VALUE(6'h3e)
  ) pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({output_update_n, async_clear_n, lockout_n,
               serial_data_in, frame_select_n, serial_clock}),
    .sync_out(pins_sync)
  );

  // Split synchronised pins
  assign sclk_s = pins_sync[0];
  assign fs_n_s = pins_sync[1];
  assign din_s = pins_sync[2];
  assign lock_n_s = pins_sync[3];
  assign clr_n_s = pins_sync[4];
  assign upd_n_s = pins_sync[5];

  // Edge detection against last synchronised level
  assign sclk_rise = sclk_s & ~state.sclk_q;
  assign sclk_fall = ~sclk_s & state.sclk_q;
  assign lock_fall = ~lock_n_s & state.lock_q;
  assign clr_fall = ~clr_n_s & state.clr_q;
  assign upd_fall = ~upd_n_s & state.upd_q;

  // Frame fields, decoded from the full shift register
  assign word = state.shift;
  assign cmd = word[`CMD_HI:`CMD_LO];
  assign addr = word[`ADDR_HI:`ADDR_LO];
  assign data = word[`DATA_HI:`DATA_LO];
  assign power_down_mode_hi = word[`PD_MODE_HI_BIT];
  assign power_down_mode_lo = word[`PD_MODE_LO_BIT];
  assign apb_access = psel & penable;

  // Clear code to output value
  always_comb begin
    unique case (state.clear_code)
      2'h1: clear_value = `CLEAR_MID;
      2'h2: clear_value = `CLEAR_FULL;
      default: clear_value = `CLEAR_ZERO; // Code 11 is never stored
    endcase
  end

  // Whole next-state logic; later sections override earlier ones
  always_comb begin
    next_state = state;
    execute = 1'b0;
    sel = 2'b00;
    next_state.sclk_q = sclk_s;
    next_state.lock_q = lock_n_s;
    next_state.clr_q = clr_n_s;
    next_state.upd_q = upd_n_s;

    // Serial receiver
    if (fs_n_s) begin
      // Frame select high ends any frame
      next_state.link_state = LINK_IDLE;
      next_state.bit_count = 6'd0;
    end else begin
      unique case (state.link_state)
        LINK_IDLE, LINK_SHIFT: begin
          if (state.link_enable) begin
            next_state.link_state = LINK_SHIFT;
            // MSB arrives first and ends at bit 31
            if (sclk_rise && state.bit_count < `FRAME_BITS) begin
              next_state.shift = {state.shift[30:0], din_s};
              next_state.bit_count = state.bit_count + 6'd1;
            end
            // Act on the falling edge after the 32nd bit
            if (sclk_fall && state.bit_count == `FRAME_BITS) begin
              execute = 1'b1;
              next_state.link_state = LINK_DONE;
            end
          end
        end
        LINK_DONE, LINK_ABORTED: begin
          // Extra clocks ignored until frame select rises
        end
      endcase
      // Lockout or clear during a frame drops it unexecuted
      if ((lock_fall || clr_fall) &&
          (state.link_state == LINK_SHIFT)) begin
        execute = 1'b0;
        next_state.link_state = LINK_ABORTED;
      end
    end

    // Command execution
    if (execute) begin
      next_state.last_cmd = {addr, cmd};
      sel[0] = (addr == `ADDR_DAC_A) || (addr == `ADDR_ALL);
      sel[1] = (addr == `ADDR_DAC_B) || (addr == `ADDR_ALL);
      unique case (cmd)
        `CMD_WRITE_INPUT, `CMD_WRITE_UPDATE,
        `CMD_WRITE_UPDATE_ALL: begin
          for (int ch = 0; ch < 2; ch++) begin
            if (sel[ch]) begin
              next_state.input_reg[ch] = data;
            end
            // Update now if held-low update, mask or command says so
            if ((sel[ch] && (cmd == `CMD_WRITE_UPDATE)) ||
                (cmd == `CMD_WRITE_UPDATE_ALL) ||
                (sel[ch] && (!upd_n_s || state.output_update_n_mask[ch]))) begin
              next_state.dac_reg[ch] = next_state.input_reg[ch];
            end
          end
        end
        `CMD_UPDATE_DAC: begin
          for (int ch = 0; ch < 2; ch++) begin
            if (sel[ch]) begin
              next_state.dac_reg[ch] = state.input_reg[ch];
            end
          end
        end
        `CMD_POWER: begin
          // Channel pick comes from select bits, not address
          if (word[`SEL_A_BIT]) begin
            sel[0] = 1'b1;
          end else begin
            sel[0] = 1'b0;
          end
          sel[1] = word[`SEL_B_BIT];
          for (int ch = 0; ch < 2; ch++) begin
            // Power-up always allowed; power-down only when unlocked
            if (sel[ch] && ({power_down_mode_hi, power_down_mode_lo} ==
                `PD_NORMAL || lock_n_s)) begin
              next_state.pd_mode[ch] =
                {power_down_mode_hi, power_down_mode_lo};
            end
          end
        end
        `CMD_CLEAR_CODE: begin
          // Code 11 means no operation
          if (word[1:0] != `CLEAR_CODE_NOP) begin
            next_state.clear_code = word[1:0];
          end
        end
        `CMD_OUTPUT_UPDATE_N_MASK: begin
          next_state.output_update_n_mask = {word[`SEL_B_BIT], word[`SEL_A_BIT]};
        end
        default: begin
          // Unused command codes do nothing
        end
      endcase
    end

    // Asynchronous output update copies input to output registers
    if (upd_fall) begin
      next_state.dac_reg = next_state.input_reg;
    end

    // Lockout falling forces every channel back to normal
    if (lock_fall) begin
      next_state.pd_mode = {`PD_NORMAL, `PD_NORMAL};
    end

    // Clear comes last so it wins over update and lockout
    if (clr_fall) begin
      next_state.input_reg = {clear_value, clear_value};
      next_state.dac_reg = {clear_value, clear_value};
      next_state.pd_mode = {`PD_NORMAL, `PD_NORMAL};
    end

    // APB slave: answer one cycle into the access phase
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (apb_access && !state.pready) begin
      next_state.pready = 1'b1;
      next_state.prdata = 32'h0000_0000;
      unique case (paddr)
        `REG_LINK_CTRL: next_state.prdata = {31'h0, state.link_enable};
        `REG_STATUS: next_state.prdata = {12'h0, state.output_update_n_mask,
          state.clear_code, state.bit_count, 3'h0,
          upd_n_s, clr_n_s, lock_n_s, state.pd_mode[1],
          state.pd_mode[0]};
        `REG_DAC_A: next_state.prdata = {state.input_reg[0],
          state.dac_reg[0]};
        `REG_DAC_B: next_state.prdata = {state.input_reg[1],
          state.dac_reg[1]};
        `REG_LAST_CMD: next_state.prdata = {24'h0, state.last_cmd};
        default: next_state.pslverr = 1'b1; // Unmapped address
      endcase
    end
    // Write lands on the edge where pready is sampled high
    if (apb_access && state.pready && pwrite &&
        paddr == `REG_LINK_CTRL) begin
      next_state.link_enable = pwdata[`LINK_ENABLE_BIT];
    end
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{
        link_state: LINK_IDLE,
        sclk_q: 1'b0,
        lock_q: 1'b1,
        clr_q: 1'b1,
        upd_q: 1'b1,
        shift: 32'h0000_0000,
        bit_count: 6'h00,
        input_reg: {`DAC_RESET, `DAC_RESET},
        dac_reg: {`DAC_RESET, `DAC_RESET},
        pd_mode: {`PD_NORMAL, `PD_NORMAL},
        clear_code: `CLEAR_CODE_RESET,
        output_update_n_mask: 2'h0,
        link_enable: `LINK_CTRL_RESET,
        last_cmd: 8'h00,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000
      };
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from state flops
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign dac_a_value = state.dac_reg[0];
  assign dac_b_value = state.dac_reg[1];
  assign pd_mode_a = state.pd_mode[0];
  assign pd_mode_b = state.pd_mode[1];

endmodule : power_down_lockout_control

// ---- verification/lockout_checker_asserts.sv ----
// Port checks for the lockout control block.
// Assumes it is bound into the block, single pclk domain.
`timescale 1ns/1ns
module lockout_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_select_n,
  input wire logic lockout_n,
  input wire logic async_clear_n,
  input wire logic output_update_n,
  input wire logic [15:0] dac_a_value,
  input wire logic [15:0] dac_b_value,
  input wire logic [1:0] pd_mode_a,
  input wire logic [1:0] pd_mode_b
);
  // One domain, so clock and reset given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_lock_hold: assert property (!lockout_n [*8] |->
    pd_mode_a == 2'h0 && pd_mode_b == 2'h0)
    else $error("power-down while lockout low");
  a_lock_fall: assert property ($fell(lockout_n) |-> ##[1:6]
    (pd_mode_a == 2'h0 && pd_mode_b == 2'h0))
    else $error("lockout fall left power-down");
  a_lock_rise: assert property (!lockout_n [*8] ##1 lockout_n |->
    (pd_mode_a == 2'h0 && pd_mode_b == 2'h0) [*4])
    else $error("power-down restored on release");
  a_clear_loads: assert property ($fell(async_clear_n) |-> ##[1:6]
    (dac_a_value == dac_b_value && pd_mode_a == 2'h0 && pd_mode_b == 2'h0))
    else $error("clear did not load both channels");
  a_pd_frame: assert property ($changed(pd_mode_a) &&
    pd_mode_a != 2'h0 |-> !$past(frame_select_n, 6))
    else $error("power-down outside a frame");
  // DAC A output moves only on a frame, update, or clear
  a_dac_idle: assert property ((frame_select_n && async_clear_n &&
    output_update_n) [*8] |=> $stable(dac_a_value))
    else $error("output changed with link idle");
  c_lock_pd: cover property ($fell(lockout_n) && pd_mode_a != 2'h0);
  c_clear: cover property ($fell(async_clear_n) && !lockout_n);
  c_err: cover property (pslverr);
endmodule : lockout_checker
bind power_down_lockout_control lockout_checker chk_i (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .frame_select_n, .lockout_n,
  .async_clear_n, .output_update_n, .dac_a_value, .dac_b_value,
  .pd_mode_a, .pd_mode_b);

// ---- verification/serial_host.sv ----
// Host serial port model that writes command frames.
// Assumes nothing of pclk; its own bit period is 160 ns.
`timescale 1ns/1ns
module serial_host (
  output logic serial_clock,
  output logic frame_select_n,
  output logic serial_data_in
);
  // Idle: clock still and low, select high
  initial begin
    serial_clock = 1'b0;
    frame_select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Sends the top n bits; fewer than 32 cuts the frame short
  task automatic send(input logic [31:0] word, input int n);
    // Step off the pclk edge the caller woke on
    #3;
    frame_select_n = 1'b0;
    #83;
    for (int i = 31; i > 31 - n; i--) begin
      serial_data_in = word[i];
      #80;
      serial_clock = 1'b1;
      #80;
      serial_clock = 1'b0;
      // Byte gap of an 8-bit port, select kept low
      if (i % 8 == 0) #240;
    end
    // Released line must not keep showing the last bit
    serial_data_in = ~serial_data_in;
    #200;
    frame_select_n = 1'b1;
    #100;
  endtask : send
endmodule : serial_host

// ---- verification/tb_top.sv ----
// Self-checking bench: APB master, serial host, pin stimulus.
// Assumes the block, its package and the host model are compiled first.
`timescale 1ns/1ns
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic serial_clock, frame_select_n, serial_data_in;
  logic lockout_n, async_clear_n, output_update_n;
  logic [15:0] dac_a_value, dac_b_value;
  logic [1:0] pd_mode_a, pd_mode_b;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  power_down_lockout_control dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_clock,
    .frame_select_n, .serial_data_in, .lockout_n, .async_clear_n,
    .output_update_n, .dac_a_value, .dac_b_value, .pd_mode_a, .pd_mode_b);
  serial_host host (.serial_clock, .frame_select_n, .serial_data_in);
  // 50 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard, well above the run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench-wide hang guard ends this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Whole frame, then time for the outputs to settle
  task automatic tx(input logic [31:0] w);
    @(posedge pclk);
    host.send(w, 32);
    repeat (4) @(posedge pclk);
  endtask : tx
  function automatic logic [31:0] wr(input logic [3:0] ad,
    input logic [15:0] v);
    return {4'h0, 4'h3, ad, v, 4'h0};
  endfunction : wr
  function automatic logic [31:0] pd(input logic [1:0] m,
    input logic b, input logic a);
    return {4'h0, 4'h4, 14'h0, m, 4'h0, b, 2'h0, a};
  endfunction : pd
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lockout_n = 1'b1; // High except where the lockout and clear tests drive it low
    async_clear_n = 1'b1;
    output_update_n = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Registers: enable bit, unmapped place, disabled link
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    tx(wr(4'h0, 16'h9999));
    check(dac_a_value, 16'h0000);
    apb(1'b1, 8'h00, 32'h1);
    $display("test registers done");
    tx(wr(4'h0, 16'h1111));
    tx(wr(4'h1, 16'h2222));
    check({dac_b_value, dac_a_value}, 32'h2222_1111);
    // Every power-down mode on channel A, then B alone
    for (int m = 1; m < 4; m++) begin
      tx(pd(m[1:0], 1'b0, 1'b1));
      check({pd_mode_b, pd_mode_a}, {2'h0, m[1:0]});
    end
    tx(pd(2'h3, 1'b1, 1'b0));
    check({pd_mode_b, pd_mode_a}, 4'hf);
    $display("test frames done");
    // Lockout falls in mid-frame while both are powered down
    fork
      host.send(wr(4'h0, 16'h3333), 32);
      begin
        repeat (40) @(posedge pclk);
        lockout_n <= 1'b0;
      end
    join
    repeat (4) @(posedge pclk);
    check(dac_a_value, 16'h1111);
    check({pd_mode_b, pd_mode_a}, 4'h0);
    tx(pd(2'h1, 1'b1, 1'b1));
    check({pd_mode_b, pd_mode_a}, 4'h0);
    tx(wr(4'h0, 16'h3333));
    check(dac_a_value, 16'h3333);
    @(posedge pclk);
    lockout_n <= 1'b1;
    repeat (8) @(posedge pclk);
    check({pd_mode_b, pd_mode_a}, 4'h0);
    tx(pd(2'h2, 1'b0, 1'b1));
    check(pd_mode_a, 2'h2);
    $display("test lockout done");
    // Clear, lockout and update together; clear code is midscale
    tx({4'h0, 4'h5, 22'h0, 2'h1});
    @(posedge pclk);
    lockout_n <= 1'b0;
    async_clear_n <= 1'b0;
    output_update_n <= 1'b0;
    repeat (8) @(posedge pclk);
    check({dac_b_value, dac_a_value}, 32'h8000_8000);
    check({pd_mode_b, pd_mode_a}, 4'h0);
    lockout_n <= 1'b1;
    async_clear_n <= 1'b1;
    output_update_n <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h8000_8000);
    $display("test clear done");
    // Input-only write, then the update pin copies it out
    tx({8'h00, 4'h1, 16'h4444, 4'h0});
    check(dac_b_value, 16'h8000);
    output_update_n <= 1'b0;
    repeat (6) @(posedge pclk);
    check(dac_b_value, 16'h4444);
    output_update_n <= 1'b1;
    // Both inputs, then the update command for both
    tx({8'h00, 4'hf, 16'h5555, 4'h0});
    check({dac_b_value, dac_a_value}, 32'h4444_8000);
    tx({8'h01, 4'hf, 20'h0});
    check({dac_b_value, dac_a_value}, 32'h5555_5555);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'hf1);
    // Mask on A makes its input write update at once
    tx({8'h06, 24'h000001});
    tx({8'h00, 4'h0, 16'h6666, 4'h0});
    check(dac_a_value, 16'h6666);
    tx({8'h02, 4'h1, 16'h7777, 4'h0});
    check({dac_b_value, dac_a_value}, 32'h7777_6666);
    // Frame cut short by select is dropped
    host.send(wr(4'h0, 16'h1234), 12);
    repeat (4) @(posedge pclk);
    check(dac_a_value, 16'h6666);
    // Status: mask A, midscale code, pins high, modes normal
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0005_0070);
    $display("test commands done");
    test_done;
  end
endmodule : tb_top
